// *** rtl/positioning_drive_param_ctrl.sv ***
module positioning_drive_param_ctrl #(
  parameter int unsigned MS_CYC_P = drive_param_pkg::MS_CYC
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  input  wire logic                         obj_req_i,
  input  wire logic                         obj_wr_i,
  input  wire logic [15:0]                  obj_index_i,
  input  wire logic [31:0]                  obj_wdata_i,
  output logic                              obj_ack_o,
  output logic                              obj_err_o,
  output logic [31:0]                       obj_rdata_o,
  input  wire logic                         pdo_valid_i,
  input  wire logic [7:0]                   pdo_cmd_i,
  input  wire logic [31:0]                  pdo_target_i,
  input  wire logic [7:0]                   nvm_node_i,
  input  wire logic                         mot_done_i,
  input  wire drive_param_pkg::drive_flags_s drv_flags_i,
  output drive_param_pkg::mot_cmd_s         mot_cmd_o,
  output logic [7:0]                        node_addr_o,
  output logic [2:0]                        bit_rate_o
);
  import drive_param_pkg::*;

  logic [7:0]  max_speed_ff, start_spd_ff, accel_ff, cmd_ff, node_ff, bitrate_ff, auto_ff;
  logic [31:0] upper_ff, lower_ff, target_ff;
  logic        node_loaded_ff;
  logic        estop_ff, reached_ff, homed_ff, badtgt_ff, pwrlost_ff, power_prev_ff, pending_ff;
  logic        loop_ff;
  motion_e     state_ff;
  logic [2:0]  speed_ff;
  logic [31:0] cyc_cnt_ff;
  logic [7:0]  ms_cnt_ff;

  logic        wr_en, rd_en, hit, wr_ok;
  logic [31:0] rd_data;
  logic [15:0] status_word;
  logic [7:0]  fault_val, nxt_cmd;
  logic        cmd_wr, halt_soft, halt_hard, tgt_in_range, start_pos, bad_xfer;
  logic        power_rise, power_fall, rehome_go, ramp_tick, manual_one, busy;
  logic [2:0]  start_idx, max_idx;

  assign wr_en = obj_req_i & obj_wr_i;
  assign rd_en = obj_req_i & ~obj_wr_i;

  assign start_idx  = SPD_START_BASE + start_spd_ff[2:0];                       // RULE_02
  assign max_idx    = SPD_MAX_BASE + max_speed_ff[2:0];                         // RULE_01
  assign busy       = (state_ff != MOT_IDLE);
  assign power_rise = drv_flags_i.power_ok & ~power_prev_ff;
  assign power_fall = ~drv_flags_i.power_ok & power_prev_ff;
  assign rehome_go  = power_rise & auto_ff[0];                                  // RULE_18

  // Object decode; a refused write leaves the object unchanged
  always_comb begin
    hit     = 1'b1;
    wr_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (obj_index_i)
      IDX_MAX_SPEED: begin
        rd_data = {24'h00_0000, max_speed_ff};
        wr_ok   = (obj_wdata_i <= {24'h00_0000, MAX_SPEED_TOP});
      end
      IDX_START_SPD: begin
        rd_data = {24'h00_0000, start_spd_ff};
        wr_ok   = (obj_wdata_i <= {24'h00_0000, START_SPD_TOP});
      end
      IDX_ACCEL: begin
        rd_data = {24'h00_0000, accel_ff};
        wr_ok   = (obj_wdata_i <= {24'h00_0000, ACCEL_TOP});
      end
      IDX_UPPER:   rd_data = upper_ff;
      IDX_LOWER:   rd_data = lower_ff;
      IDX_HALT: begin
        wr_ok = (obj_wdata_i == {24'h00_0000, HALT_RAMP}) || (obj_wdata_i == {24'h00_0000, HALT_NOW});
      end
      IDX_FAULT: begin
        rd_data = {24'h00_0000, fault_val};
        wr_ok   = 1'b0;
      end
      IDX_COMMAND: begin
        rd_data = {24'h00_0000, cmd_ff};
        wr_ok   = (obj_wdata_i[31:8] == 24'h00_0000);
      end
      IDX_STATUS: begin
        rd_data = {16'h0000, status_word};
        wr_ok   = 1'b0;                                                          // RULE_20
      end
      IDX_NODE: begin
        rd_data = {24'h00_0000, node_ff};
        wr_ok   = (obj_wdata_i >= {24'h00_0000, NODE_MIN}) && (obj_wdata_i <= {24'h00_0000, NODE_MAX});
      end
      IDX_BITRATE: begin
        rd_data = {24'h00_0000, bitrate_ff};
        wr_ok   = (obj_wdata_i <= {24'h00_0000, BITRATE_TOP});
      end
      IDX_AUTO_HOME: begin
        rd_data = {24'h00_0000, auto_ff};
        wr_ok   = (obj_wdata_i <= {24'h00_0000, AUTO_HOME_TOP});
      end
      default: begin
        hit   = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  assign cmd_wr    = pdo_valid_i | (wr_en & wr_ok & (obj_index_i == IDX_COMMAND));
  assign nxt_cmd   = pdo_valid_i ? pdo_cmd_i : (cmd_wr ? obj_wdata_i[7:0] : cmd_ff);
  assign halt_soft = wr_en & (obj_index_i == IDX_HALT) & (obj_wdata_i == {24'h00_0000, HALT_RAMP});
  assign halt_hard = wr_en & (obj_index_i == IDX_HALT) & (obj_wdata_i == {24'h00_0000, HALT_NOW});
  assign tgt_in_range = ($signed(pdo_target_i) <= $signed(upper_ff)) &&          // RULE_04
                        ($signed(pdo_target_i) >= $signed(lower_ff));            // RULE_05
  assign start_pos = pdo_valid_i & pdo_cmd_i[CMD_XFER] & tgt_in_range;           // RULE_09
  assign bad_xfer  = pdo_valid_i & pdo_cmd_i[CMD_XFER] & ~tgt_in_range;          // RULE_19
  assign manual_one = nxt_cmd[CMD_UP] ^ nxt_cmd[CMD_DOWN];

  assign fault_val = estop_ff ? FAULT_ESTOP : (busy ? FAULT_BUSY : FAULT_READY); // RULE_07

  always_comb begin
    status_word               = 16'h0000;
    status_word[STS_REACHED]  = reached_ff;                                      // RULE_12
    status_word[STS_ACTIVE]   = busy;
    status_word[STS_HOMED]    = homed_ff;
    status_word[STS_POWER]    = drv_flags_i.power_ok;
    status_word[STS_POT]      = drv_flags_i.pot_err;                             // RULE_13
    status_word[STS_SECOND]   = drv_flags_i.second_run;
    status_word[STS_OPPOSITE] = drv_flags_i.opposite;
    status_word[STS_OBSTRUCT] = drv_flags_i.obstruct;                            // RULE_14
    status_word[STS_MANROT]   = drv_flags_i.manual_rot;
    status_word[STS_BADTGT]   = badtgt_ff;
    status_word[STS_PWRLOST]  = pwrlost_ff;                                      // RULE_15
    status_word[STS_LIMPOS]   = drv_flags_i.lim_pos;
    status_word[STS_LIMNEG]   = drv_flags_i.lim_neg;
  end

  // Object answer one cycle after the request
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      obj_ack_o   <= 1'b0;
      obj_err_o   <= 1'b0;
      obj_rdata_o <= 32'h0000_0000;
    end else begin
      obj_ack_o   <= obj_req_i;
      obj_err_o   <= obj_req_i & (~hit | (obj_wr_i & ~wr_ok));
      obj_rdata_o <= rd_en ? rd_data : 32'h0000_0000;
    end
  end

  // Parameter objects
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      max_speed_ff <= RST_MAX_SPEED;
      start_spd_ff <= RST_START_SPD;
      accel_ff     <= RST_ACCEL;
      upper_ff     <= RST_UPPER;
      lower_ff     <= RST_LOWER;
      bitrate_ff   <= RST_BITRATE;
      auto_ff      <= RST_AUTO_HOME;
      cmd_ff       <= RST_COMMAND;
    end else begin
      cmd_ff <= nxt_cmd;
      if (wr_en && wr_ok) begin
        case (obj_index_i)
          IDX_MAX_SPEED: max_speed_ff <= obj_wdata_i[7:0];                       // RULE_01
          IDX_START_SPD: start_spd_ff <= obj_wdata_i[7:0];                       // RULE_02
          IDX_ACCEL:     accel_ff     <= obj_wdata_i[7:0];                       // RULE_03
          IDX_UPPER:     upper_ff     <= obj_wdata_i;                            // RULE_04
          IDX_LOWER:     lower_ff     <= obj_wdata_i;                            // RULE_05
          IDX_BITRATE:   bitrate_ff   <= obj_wdata_i[7:0];                       // RULE_17
          IDX_AUTO_HOME: auto_ff      <= obj_wdata_i[7:0];                       // RULE_18
          default: ;
        endcase
      end
    end
  end

  // Node number: storage value taken on the first edge after reset release
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      node_ff        <= RST_NODE;
      node_loaded_ff <= 1'b0;
    end else begin
      node_loaded_ff <= 1'b1;
      if (!node_loaded_ff) begin
        if (nvm_node_i >= NODE_MIN && nvm_node_i <= NODE_MAX) begin
          node_ff <= nvm_node_i;                                                 // RULE_16
        end
      end else if (wr_en && wr_ok && obj_index_i == IDX_NODE) begin
        node_ff <= obj_wdata_i[7:0];                                             // RULE_16
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      estop_ff      <= 1'b0;
      badtgt_ff     <= 1'b0;
      pwrlost_ff    <= 1'b0;
      power_prev_ff <= 1'b0;
    end else begin
      power_prev_ff <= drv_flags_i.power_ok;
      if (halt_hard) begin
        estop_ff <= 1'b1;                                                        // RULE_06
      end else if (cmd_wr) begin
        estop_ff <= 1'b0;                                                        // RULE_20
      end
      if (bad_xfer) begin
        badtgt_ff <= 1'b1;                                                       // RULE_19
      end else if (start_pos) begin
        badtgt_ff <= 1'b0;
      end
      if (power_fall) begin
        pwrlost_ff <= 1'b1;                                                      // RULE_15
      end else if (rd_en && obj_index_i == IDX_STATUS) begin
        pwrlost_ff <= 1'b0;
      end
    end
  end

  // Ramp timer: one tick per speed step at the selected acceleration
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_cnt_ff <= 32'h0000_0000;
      ms_cnt_ff  <= 8'h00;
      ramp_tick  <= 1'b0;
    end else begin
      ramp_tick <= 1'b0;
      if (!busy) begin
        cyc_cnt_ff <= 32'h0000_0000;
        ms_cnt_ff  <= 8'h00;
      end else if (cyc_cnt_ff == MS_CYC_P - 32'h1) begin
        cyc_cnt_ff <= 32'h0000_0000;
        if (ms_cnt_ff == RAMP_STEP_MS[accel_ff[2:0]] - 8'h01) begin               // RULE_03
          ms_cnt_ff <= 8'h00;
          ramp_tick <= 1'b1;
        end else begin
          ms_cnt_ff <= ms_cnt_ff + 8'h01;
        end
      end else begin
        cyc_cnt_ff <= cyc_cnt_ff + 32'h1;
      end
    end
  end

  // Motion sequencing
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= MOT_IDLE;
      speed_ff   <= 3'h0;
      target_ff  <= 32'h0000_0000;
      pending_ff <= 1'b0;
      loop_ff    <= 1'b1;
      reached_ff <= 1'b0;
      homed_ff   <= 1'b0;
    end else begin
      if (start_pos) begin
        target_ff  <= pdo_target_i;
        reached_ff <= 1'b0;
        loop_ff    <= ~pdo_cmd_i[CMD_NOLOOP];                                    // RULE_11
      end
      if (!nxt_cmd[CMD_RELEASE] || halt_hard) begin
        state_ff   <= MOT_IDLE;                                                  // RULE_10
        speed_ff   <= 3'h0;
        pending_ff <= 1'b0;
      end else if (halt_soft && busy) begin
        state_ff   <= MOT_STOPPING;                                              // RULE_06
        pending_ff <= 1'b0;
      end else begin
        case (state_ff)
          MOT_IDLE: begin
            if (rehome_go || (start_pos && pdo_cmd_i[CMD_HOME] && !homed_ff)) begin
              state_ff   <= MOT_HOME;                                            // RULE_18
              speed_ff   <= start_idx;
              pending_ff <= 1'b1;
            end else if (start_pos) begin
              state_ff <= MOT_POS;
              speed_ff <= start_idx;
            end else if (nxt_cmd[CMD_HOME] && !homed_ff) begin
              state_ff <= MOT_HOME;                                              // RULE_11
              speed_ff <= start_idx;
            end else if (manual_one) begin
              state_ff <= MOT_MANUAL;                                            // RULE_08
              speed_ff <= start_idx;
            end
          end
          MOT_HOME: begin
            if (mot_done_i) begin
              homed_ff   <= 1'b1;
              pending_ff <= 1'b0;
              state_ff   <= pending_ff ? MOT_POS : MOT_IDLE;
              speed_ff   <= pending_ff ? start_idx : 3'h0;
            end
          end
          MOT_POS: begin
            if (mot_done_i) begin
              state_ff   <= MOT_IDLE;
              speed_ff   <= 3'h0;
              reached_ff <= 1'b1;
            end else if (speed_ff > max_idx) begin
              speed_ff <= max_idx;                                               // RULE_01
            end else if (ramp_tick && speed_ff < max_idx) begin
              speed_ff <= speed_ff + 3'h1;                                       // RULE_03
            end
          end
          MOT_STOPPING: begin
            if (speed_ff <= start_idx || mot_done_i) begin
              state_ff <= MOT_IDLE;
              speed_ff <= 3'h0;
            end else if (ramp_tick) begin
              speed_ff <= speed_ff - 3'h1;
            end
          end
          MOT_MANUAL: begin
            if (start_pos) begin
              state_ff <= MOT_POS;                                               // RULE_09
              speed_ff <= start_idx;
            end else if (!manual_one) begin
              state_ff <= MOT_IDLE;
              speed_ff <= 3'h0;
            end else begin
              speed_ff <= start_idx;                                             // RULE_02
            end
          end
          default: begin
            state_ff <= MOT_IDLE;
            speed_ff <= 3'h0;
          end
        endcase
      end
    end
  end

  // Registered drive outputs
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mot_cmd_o   <= '0;
      node_addr_o <= RST_NODE;
      bit_rate_o  <= RST_BITRATE[2:0];
    end else begin
      mot_cmd_o.enable   <= (state_ff != MOT_IDLE);
      mot_cmd_o.dir_up   <= (state_ff == MOT_MANUAL) ? cmd_ff[CMD_UP] : ($signed(target_ff) >= 0);
      mot_cmd_o.use_loop <= loop_ff;
      mot_cmd_o.mode     <= state_ff;
      mot_cmd_o.speed    <= speed_ff;
      mot_cmd_o.target   <= target_ff;
      node_addr_o        <= node_ff;
      bit_rate_o         <= bitrate_ff[2:0];                                     // RULE_17
    end
  end

  AST_RESET_MAX: assert property (@(posedge clk_sys_i) $fell(rst_i) |-> max_speed_ff == RST_MAX_SPEED) // RULE_01
    else $error("max speed reset value wrong");
  AST_START_SPEED: assert property (@(posedge clk_sys_i) disable iff (rst_i)                           // RULE_02
    (state_ff == MOT_MANUAL) |-> speed_ff == $past(start_idx)) else $error("manual run not at start speed");
  AST_RAMP_CAP: assert property (@(posedge clk_sys_i) disable iff (rst_i)                              // RULE_03
    (state_ff == MOT_POS) |-> speed_ff <= $past(max_idx)) else $error("ramp above max speed");
  AST_HARD_STOP: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_06
    halt_hard |=> state_ff == MOT_IDLE && estop_ff ##1 mot_cmd_o.enable == 1'b0)
    else $error("emergency stop not immediate");
  AST_SOFT_STOP: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_06
    (halt_soft && busy && nxt_cmd[CMD_RELEASE] && !halt_hard) |=> state_ff == MOT_STOPPING)
    else $error("ramp stop not entered");
  AST_FAULT_VAL: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_07
    (rd_en && obj_index_i == IDX_FAULT) |=> obj_rdata_o[7:0] == ($past(estop_ff) ? FAULT_ESTOP :
    ($past(busy) ? FAULT_BUSY : FAULT_READY))) else $error("fault object value wrong");
  AST_MANUAL_GO: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_08
    (state_ff == MOT_IDLE && manual_one && nxt_cmd[CMD_RELEASE] && !halt_hard && !start_pos &&
    !rehome_go && !(nxt_cmd[CMD_HOME] && !homed_ff)) |=> state_ff == MOT_MANUAL)
    else $error("manual run not started");
  AST_XFER_ONLY: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_09
    (state_ff == MOT_IDLE ##1 state_ff == MOT_POS) |-> $past(start_pos))
    else $error("positioning without transfer bit");
  AST_RELEASE: assert property (@(posedge clk_sys_i) disable iff (rst_i)                               // RULE_10
    !cmd_ff[CMD_RELEASE] |-> state_ff == MOT_IDLE ##1 !mot_cmd_o.enable)
    else $error("motion without release");
  AST_BAD_TGT: assert property (@(posedge clk_sys_i) disable iff (rst_i)                               // RULE_19
    bad_xfer |=> badtgt_ff && target_ff == $past(target_ff)) else $error("bad target accepted");
  AST_STATUS_RO: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_20
    (wr_en && obj_index_i == IDX_STATUS) |=> obj_err_o) else $error("status write not refused");
  AST_NODE_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)                             // RULE_16
    (!node_loaded_ff && nvm_node_i >= NODE_MIN && nvm_node_i <= NODE_MAX) |=> node_ff == $past(nvm_node_i))
    else $error("node number not loaded");
endmodule // positioning_drive_param_ctrl

// *** rtl/drive_param_pkg.sv ***
// Summary of operation
// RULE_01 - Max speed code 0..3 picks approach speed; resets to 3.
// RULE_02 - Start speed code 0..3, default 1, used for homing and manual runs.
// RULE_03 - Acceleration code 0..4, default 2, sets ramp from start to max speed.
// RULE_04 - Signed upper target limit, default 16000.
// RULE_05 - Signed lower target limit, default 125.
// RULE_06 - Halt write 32 ramps down and stops; 128 stops at once.
// RULE_07 - Fault object reads 64 when ready, 128 during emergency stop.
// RULE_08 - Command bit 0 runs manually up, bit 1 manually down.
// RULE_09 - Positioning starts only when bit 2 comes with the target transfer.
// RULE_10 - No motion unless release bit 4 is set.
// RULE_11 - Bit 6 runs without reference loop; bit 7 runs initial reference loop.
// RULE_12 - Status bits 0,2,3,4: reached, stage active, homed, power present.
// RULE_13 - Status bits 6,7,8: pot error, second run, opposite movement.
// RULE_14 - Status bits 10,11,12: obstruction, manual rotation, bad target.
// RULE_15 - Status bit 13 power was lost; bits 14,15 range limits.
// RULE_16 - Node number loaded from storage after reset, writable, default 1.
// RULE_17 - Bit-rate code 0..4 selects 20..1000 kbit/s, default 2.
// RULE_18 - Auto rehome setting 1 homes and repositions after power returns.
// RULE_19 - Out-of-range target is refused without motion and flags bad target.
// RULE_20 - Status word is read only; fault returns to ready after new command.
package drive_param_pkg;
  localparam logic [15:0] IDX_MAX_SPEED  = 16'h2012;
  localparam logic [15:0] IDX_START_SPD  = 16'h2013;
  localparam logic [15:0] IDX_ACCEL      = 16'h2014;
  localparam logic [15:0] IDX_UPPER      = 16'h2016;
  localparam logic [15:0] IDX_LOWER      = 16'h2017;
  localparam logic [15:0] IDX_HALT       = 16'h2018;
  localparam logic [15:0] IDX_FAULT      = 16'h2019;
  localparam logic [15:0] IDX_COMMAND    = 16'h2024;
  localparam logic [15:0] IDX_STATUS     = 16'h2025;
  localparam logic [15:0] IDX_NODE       = 16'h2026;
  localparam logic [15:0] IDX_BITRATE    = 16'h2027;
  localparam logic [15:0] IDX_AUTO_HOME  = 16'h2029;

  localparam logic [7:0]  RST_MAX_SPEED  = 8'h03;
  localparam logic [7:0]  RST_START_SPD  = 8'h01;
  localparam logic [7:0]  RST_ACCEL      = 8'h02;
  localparam logic [31:0] RST_UPPER      = 32'h0000_3e80;
  localparam logic [31:0] RST_LOWER      = 32'h0000_007d;
  localparam logic [7:0]  RST_COMMAND    = 8'h00;
  localparam logic [7:0]  RST_NODE       = 8'h01;
  localparam logic [7:0]  RST_BITRATE    = 8'h02;
  localparam logic [7:0]  RST_AUTO_HOME  = 8'h00;

  localparam logic [7:0]  MAX_SPEED_TOP  = 8'h03;
  localparam logic [7:0]  START_SPD_TOP  = 8'h03;
  localparam logic [7:0]  ACCEL_TOP      = 8'h04;
  localparam logic [7:0]  BITRATE_TOP    = 8'h04;
  localparam logic [7:0]  AUTO_HOME_TOP  = 8'h01;
  localparam logic [7:0]  NODE_MIN       = 8'h01;
  localparam logic [7:0]  NODE_MAX       = 8'h7f;

  localparam logic [7:0]  HALT_RAMP      = 8'h20;
  localparam logic [7:0]  HALT_NOW       = 8'h80;
  localparam logic [7:0]  FAULT_READY    = 8'h40;
  localparam logic [7:0]  FAULT_ESTOP    = 8'h80;
  localparam logic [7:0]  FAULT_BUSY     = 8'h00;

  localparam int CMD_UP      = 0;
  localparam int CMD_DOWN    = 1;
  localparam int CMD_XFER    = 2;
  localparam int CMD_RELEASE = 4;
  localparam int CMD_NOLOOP  = 6;
  localparam int CMD_HOME    = 7;

  localparam int STS_REACHED  = 0;
  localparam int STS_ACTIVE   = 2;
  localparam int STS_HOMED    = 3;
  localparam int STS_POWER    = 4;
  localparam int STS_POT      = 6;
  localparam int STS_SECOND   = 7;
  localparam int STS_OPPOSITE = 8;
  localparam int STS_OBSTRUCT = 10;
  localparam int STS_MANROT   = 11;
  localparam int STS_BADTGT   = 12;
  localparam int STS_PWRLOST  = 13;
  localparam int STS_LIMPOS   = 14;
  localparam int STS_LIMNEG   = 15;

  // Speed steps of the motor driver: 1..4 start speeds, 4..7 approach speeds
  localparam logic [2:0]  SPD_START_BASE = 3'h1;
  localparam logic [2:0]  SPD_MAX_BASE   = 3'h4;

  // Time per speed step in ms for each acceleration code (code 0 longest)
  localparam logic [4:0][7:0] RAMP_STEP_MS = {8'h29, 8'h32, 8'h3e, 8'h53, 8'h7d};
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {MOT_IDLE, MOT_HOME, MOT_POS, MOT_STOPPING, MOT_MANUAL} motion_e;

  typedef struct packed {
    logic power_ok;
    logic pot_err;
    logic second_run;
    logic opposite;
    logic obstruct;
    logic manual_rot;
    logic lim_pos;
    logic lim_neg;
  } drive_flags_s;

  typedef struct packed {
    logic        enable;
    logic        dir_up;
    logic        use_loop;
    motion_e     mode;
    logic [2:0]  speed;
    logic [31:0] target;
  } mot_cmd_s;
endpackage

// *** tb/obj_master.sv ***
module obj_master (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] rdata_i,
  output logic             req_o,
  output logic             wr_o,
  output logic [15:0]      idx_o,
  output logic [31:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_o, wr_o, idx_o, wdata_o} = '0;
  // One-cycle request; the answer stands one cycle after it is taken
  task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
                      output logic e, output logic [31:0] q);
    @(posedge clk_i);
    req_o <= 1'b1;
    wr_o <= w;
    idx_o <= i;
    wdata_o <= d;
    @(posedge clk_i);
    req_o <= 1'b0;
    idx_o <= ~i;
    wdata_o <= ~d;
    #1;
    e = err_i;
    q = rdata_i;
  endtask
endmodule // obj_master

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drive_param_pkg::*;
  logic clk_sys_i, rst_i, obj_req_i, obj_wr_i, obj_ack_o, obj_err_o, pdo_valid_i, mot_done_i, e;
  logic [15:0]  obj_index_i;
  logic [31:0]  obj_wdata_i, obj_rdata_o, pdo_target_i, v, q, lfsr_r = 32'h1158, a = 32'h2;
  logic [7:0]   pdo_cmd_i, nvm_node_i, node_addr_o;
  logic [2:0]   bit_rate_o;
  drive_flags_s drv_flags_i;
  mot_cmd_s     mot_cmd_o;
  int           fail_count = 0, checks = 0, cyc = 0;
  positioning_drive_param_ctrl #(.MS_CYC_P(4)) dut_u (.clk_sys_i, .rst_i, .obj_req_i, .obj_wr_i,
    .obj_index_i, .obj_wdata_i, .obj_ack_o, .obj_err_o, .obj_rdata_o, .pdo_valid_i, .pdo_cmd_i,
    .pdo_target_i, .nvm_node_i, .mot_done_i, .drv_flags_i, .mot_cmd_o, .node_addr_o, .bit_rate_o);
  obj_master m_u (.clk_i(clk_sys_i), .ack_i(obj_ack_o), .err_i(obj_err_o), .rdata_i(obj_rdata_o),
    .req_o(obj_req_i), .wr_o(obj_wr_i), .idx_o(obj_index_i), .wdata_o(obj_wdata_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] sts(input drive_flags_s f);
    return {f.lim_neg, f.lim_pos, 2'h0, f.manual_rot, f.obstruct, 1'b0, f.opposite, f.second_run,
            f.pot_err, 1'b0, f.power_ok, 4'h0};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d, input logic xe,
                     input logic [31:0] xq);
    m_u.xfer(w, i, d, e, q);
    chk("ack", {31'h0, obj_ack_o}, 32'h1);
    chk("err", {31'h0, e}, {31'h0, xe});
    chk("data", q, xq);
  endtask
  task automatic pdo(input logic [7:0] c, input logic [31:0] t);
    @(posedge clk_sys_i);
    pdo_valid_i <= 1'b1;
    pdo_cmd_i <= c;
    pdo_target_i <= t;
    @(posedge clk_sys_i);
    pdo_valid_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_i, pdo_valid_i, mot_done_i, pdo_cmd_i, pdo_target_i, drv_flags_i} = '0;
    rst_i = 1'b1;
    nvm_node_i = 8'h05;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    acc(0, IDX_MAX_SPEED, 0, 0, 32'h3);
    acc(0, IDX_START_SPD, 0, 0, 32'h1);
    acc(0, IDX_ACCEL, 0, 0, 32'h2);
    acc(0, IDX_UPPER, 0, 0, 32'h3e80);
    acc(0, IDX_LOWER, 0, 0, 32'h7d);
    acc(0, IDX_NODE, 0, 0, 32'h5);
    acc(0, IDX_BITRATE, 0, 0, 32'h2);
    acc(0, IDX_AUTO_HOME, 0, 0, 32'h0);
    acc(0, IDX_FAULT, 0, 0, 32'h40);
    acc(1, IDX_STATUS, 0, 1, 0);
    acc(1, IDX_MAX_SPEED, 4, 1, 0);
    acc(1, IDX_BITRATE, 5, 1, 0);
    acc(1, IDX_NODE, 0, 1, 0);
    acc(1, IDX_NODE, 32'h7f, 0, 0);
    acc(0, IDX_NODE, 0, 0, 32'h7f);
    chk("node", {24'h0, node_addr_o}, 32'h7f);
    chk("rate", {29'h0, bit_rate_o}, 32'h2);
    for (int k = 0; k < 8; k++) begin
      lfsr_r = lfsr(lfsr_r);
      v = lfsr_r % 6;
      acc(1, IDX_ACCEL, v, v > 4, 0);
      if (v <= 4) a = v;
      acc(0, IDX_ACCEL, 0, 0, a);
      @(posedge clk_sys_i);
      drv_flags_i <= lfsr_r[15:8];
      m_u.xfer(0, IDX_STATUS, 0, e, q);
      chk("status", q & 32'hcdd0, {16'h0, sts(drv_flags_i)});
    end
    pdo(8'h14, 32'd500);
    chk("en", mot_cmd_o.enable, 1);
    chk("mode", mot_cmd_o.mode, MOT_POS);
    chk("target", mot_cmd_o.target, 32'd500);
    chk("loop", mot_cmd_o.use_loop, 1);
    repeat (4 * RAMP_STEP_MS[a[2:0]]) @(posedge clk_sys_i);
    #1;
    chk("speed", mot_cmd_o.speed, 3'h2);
    @(posedge clk_sys_i);
    #1;
    chk("speed", mot_cmd_o.speed, 3'h3);
    acc(1, IDX_HALT, 32'd32, 0, 0);
    @(posedge clk_sys_i);
    #1;
    chk("mode", mot_cmd_o.mode, MOT_STOPPING);
    for (int k = 0; k < 5000 && mot_cmd_o.enable === 1'b1; k++) @(posedge clk_sys_i);
    chk("en", mot_cmd_o.enable, 0);
    pdo(8'h14, 32'd600);
    acc(1, IDX_HALT, 32'd128, 0, 0);
    acc(0, IDX_FAULT, 0, 0, 32'h80);
    chk("en", mot_cmd_o.enable, 0);
    pdo(8'h00, 32'd0);
    acc(0, IDX_FAULT, 0, 0, 32'h40);
    pdo(8'h04, 32'd700);
    chk("en", mot_cmd_o.enable, 0);
    pdo(8'h14, 32'd10);
    chk("en", mot_cmd_o.enable, 0);
    m_u.xfer(0, IDX_STATUS, 0, e, q);
    chk("badtgt", q[12], 1);
    pdo(8'h11, 32'd0);
    chk("mode", mot_cmd_o.mode, MOT_MANUAL);
    chk("speed", mot_cmd_o.speed, 3'h2);
    chk("dir", mot_cmd_o.dir_up, 1);
    pdo(8'h12, 32'd0);
    chk("dir", mot_cmd_o.dir_up, 0);
    pdo(8'h14, 32'd800);
    @(posedge clk_sys_i);
    mot_done_i <= 1'b1;
    @(posedge clk_sys_i);
    mot_done_i <= 1'b0;
    m_u.xfer(0, IDX_STATUS, 0, e, q);
    chk("reached", q[0], 1);
    pdo(8'h90, 32'd0);
    chk("mode", mot_cmd_o.mode, MOT_HOME);
    stop_test();
  end
endmodule // tb
